//--- hdl/dma_chan_defs.svh
// Overview of operation
// - Source-side mode bit: 0 selects normal mode (reset), 1 selects block transfer mode.
// - Reset and standby entry force the destination-side control register to zero.
// - Transfers run only while master enable and channel enable are both 1.
// - Non-maskable interrupt clears master enable; transfer suspends, resumes when set again.
// - Master enable sets only after a read seeing it 0, then a write of 1.
// - Reserved bit 6 of destination-side control stores and returns written values.
// - Destination address fixed when step enable is 0; else direction picks up or down.
// - Destination address steps by 1 for byte transfers, 2 for word transfers.
// - Block area select: 0 makes destination the block area, 1 the source.
// - Normal mode sources: 000 burst, 010 cycle-steal, 110 pin fall, 111 pin low.
// - Block mode sources: 000 to 011 timer channels 0 to 3, 110 pin fall.
// - Channels sharing one interrupt source activate in fixed priority, highest first.
// - On completion channel enable clears; completion interrupt raised if enabled.
// - Block mode decrements block size counter per transfer, reloads it at zero.
// - Cycle-steal auto-request releases the bus after every single transfer.
// - Burst auto-request keeps the bus until done unless a higher master asks.
`ifndef DMA_CHAN_DEFS_SVH
`define DMA_CHAN_DEFS_SVH

`define OFF_SRC_CTRL 8'h00
`define OFF_DST_CTRL 8'h04
`define OFF_SRC_ADDR 8'h08
`define OFF_DST_ADDR 8'h0C
`define OFF_COUNT 8'h10
`define OFF_BLOCKS 8'h14
`define OFF_IRQ_STAT 8'h18
`define OFF_IRQ_MASK 8'h1C
`define OFF_STATUS 8'h20

`define CTRL_RESET 8'h00
`define BIT_ENABLE 7
`define BIT_WORD 6
`define BIT_RESV 6
`define BIT_DIR 5
`define BIT_STEP 4
`define BIT_IRQ_EN 3
`define BIT_AREA 3
`define BIT_MODE 0

`define SEL_BURST 3'h0
`define SEL_STEAL 3'h2
`define SEL_FALL 3'h6
`define SEL_LOW 3'h7

`define IRQ_END 0
`define IRQ_NMI 1
`endif

//--- hdl/dma_chan_pkg.sv
package dma_chan_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REQ = 2'b01,
        ST_XFER = 2'b11,
        ST_REL = 2'b10
    } chan_state_t;

    typedef struct packed {
        logic valid;
        logic word;
        logic [23:0] src;
        logic [23:0] dst;
    } xfer_t;
endpackage

//--- hdl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rst_n,
    // Raw pins and their settled copies.
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    wire logic [WIDTH-1:0] agree = ~(s2_q ^ s3_q);

    if (WIDTH < 1) begin : g_bad
        $error("pin_sync needs at least one pin");
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level <= '0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // A change is taken only once the last two stages agree.
            level <= (agree & s2_q) | (~agree & level);
        end
    end
endmodule

//--- hdl/dma_full_address_channel.sv
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "dma_chan_defs.svh"
module dma_full_address_channel #(
    parameter int TIMER_CH = 4
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Events and pins.
    input wire logic nmi_pin,
    input wire logic standby,
    input wire logic [TIMER_CH-1:0] timer_match,
    input wire logic external_request_pin,
    input wire logic higher_channel_active,
    // Bus arbitration.
    input wire logic bus_grant,
    input wire logic bus_preempt,
    output logic bus_request,
    // Transfer and interrupts.
    output dma_chan_pkg::xfer_t xfer,
    output logic transfer_end_interrupt,
    output logic irq
);
    import dma_chan_pkg::*;

    if (TIMER_CH < 1 || TIMER_CH > 4) begin : g_bad
        $error("TIMER_CH must be 1 to 4");
    end

    function automatic logic [23:0] step_addr(input logic [23:0] a, input logic en,
                                              input logic dir, input logic word);
        logic [23:0] d;
        d = word ? 24'h00_0002 : 24'h00_0001;
        if (!en)
            step_addr = a;
        else if (dir)
            step_addr = a - d;
        else
            step_addr = a + d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisation.
    logic [1:0] rs_q;
    wire logic rst_n = rs_q[1];
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            rs_q <= 2'b00;
        else
            rs_q <= {rs_q[0], 1'b1};
    end

    // The request pin idles high, so it goes through the synchroniser inverted; a reset copy then matches idle.
    logic [1:0] pins_s;
    pin_sync #(.WIDTH(2)) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin({nmi_pin, ~external_request_pin}),
        .level(pins_s)
    );
    wire logic nmi_s = pins_s[1];
    wire logic ereq_s = ~pins_s[0];
    logic nmi_prev_q;
    logic ereq_prev_q;
    wire logic nmi_rise = nmi_s & ~nmi_prev_q;
    wire logic ereq_fall = ~ereq_s & ereq_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [7:0] src_ctrl_q;
    logic [7:0] dst_ctrl_q;
    logic [23:0] src_addr_q;
    logic [23:0] dst_addr_q;
    logic [15:0] count_q;
    logic [15:0] blocks_q;
    logic [23:0] blk_start_q;
    logic [1:0] stat_q;
    logic [1:0] mask_q;
    logic armed_me_q;
    logic armed_ce_q;
    logic pend_q;
    chan_state_t state_q;
    chan_state_t state_d;

    wire logic wr_en = psel & penable & pwrite;
    wire logic rd_en = psel & penable & ~pwrite;
    wire logic wr_src_ctrl = wr_en && paddr == `OFF_SRC_CTRL;
    wire logic wr_dst_ctrl = wr_en && paddr == `OFF_DST_CTRL;
    wire logic wr_src_addr = wr_en && paddr == `OFF_SRC_ADDR;
    wire logic wr_dst_addr = wr_en && paddr == `OFF_DST_ADDR;
    wire logic wr_count = wr_en && paddr == `OFF_COUNT;
    wire logic wr_blocks = wr_en && paddr == `OFF_BLOCKS;
    wire logic wr_stat = wr_en && paddr == `OFF_IRQ_STAT;
    wire logic wr_mask = wr_en && paddr == `OFF_IRQ_MASK;
    wire logic rd_src_ctrl = rd_en && paddr == `OFF_SRC_CTRL;
    wire logic rd_dst_ctrl = rd_en && paddr == `OFF_DST_CTRL;

    wire logic me = dst_ctrl_q[`BIT_ENABLE];
    wire logic ce = src_ctrl_q[`BIT_ENABLE];
    wire logic run = me & ce;
    wire logic blk = src_ctrl_q[`BIT_MODE];
    wire logic word = src_ctrl_q[`BIT_WORD];
    wire logic [2:0] sel = dst_ctrl_q[2:0];
    wire logic area_src = dst_ctrl_q[`BIT_AREA];

    ////////////////////////////////////////////////////////////////////////////
    // Activation decode.
    wire logic auto_burst = !blk && sel == `SEL_BURST;
    wire logic auto_steal = !blk && sel == `SEL_STEAL;
    wire logic low_level = !blk && sel == `SEL_LOW && !ereq_s;
    wire logic use_timer = blk && !sel[2] && int'(sel[1:0]) < TIMER_CH;
    wire logic timer_hit = use_timer && timer_match[sel[1:0]];
    wire logic fall_hit = sel == `SEL_FALL && ereq_fall;
    wire logic event_set = run && (timer_hit || fall_hit);
    wire logic activate = auto_burst || auto_steal || low_level || pend_q;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer step and counts.
    wire logic step = state_q == ST_XFER && bus_grant && run;
    wire logic blk_last = count_q[15:8] == 8'h01;
    wire logic norm_done = !blk && count_q == 16'h0001;
    wire logic blk_end = blk && blk_last;
    wire logic done = step && (norm_done || (blk_end && blocks_q == 16'h0001));
    wire logic [23:0] src_next = step_addr(src_addr_q, src_ctrl_q[`BIT_STEP], src_ctrl_q[`BIT_DIR], word);
    wire logic [23:0] dst_next = step_addr(dst_addr_q, dst_ctrl_q[`BIT_STEP],
                                           dst_ctrl_q[`BIT_DIR], word);
    wire logic restore_src = blk_end && area_src;
    wire logic restore_dst = blk_end && !area_src;

    // One block per request in block mode; burst runs until done unless preempted; a single unit per request otherwise.
    wire logic leave_xfer = done || blk_end || (!blk && !auto_burst) ||
                            (auto_burst && bus_preempt);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (run && activate && !higher_channel_active) state_d = ST_REQ;
            ST_REQ: begin
                if (!run)
                    state_d = ST_IDLE;
                else if (bus_grant)
                    state_d = ST_XFER;
            end
            ST_XFER: begin
                if (!run)
                    state_d = ST_IDLE;
                else if (!bus_grant)
                    state_d = ST_REQ;
                else if (leave_xfer)
                    state_d = ST_REL;
            end
            ST_REL: state_d = ST_IDLE;
        endcase
    end

    assign bus_request = state_q == ST_REQ || state_q == ST_XFER;

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: registered data, zero wait states.
    logic [31:0] rdata_d;
    logic hit_d;
    always_comb begin
        hit_d = 1'b1;
        unique case (paddr)
            `OFF_SRC_CTRL: rdata_d = {24'h00_0000, src_ctrl_q};
            `OFF_DST_CTRL: rdata_d = {24'h00_0000, dst_ctrl_q};
            `OFF_SRC_ADDR: rdata_d = {8'h00, src_addr_q};
            `OFF_DST_ADDR: rdata_d = {8'h00, dst_addr_q};
            `OFF_COUNT: rdata_d = {16'h0000, count_q};
            `OFF_BLOCKS: rdata_d = {16'h0000, blocks_q};
            `OFF_IRQ_STAT: rdata_d = {30'h0000_0000, stat_q};
            `OFF_IRQ_MASK: rdata_d = {30'h0000_0000, mask_q};
            `OFF_STATUS: rdata_d = {29'h0000_0000, pend_q, state_q};
            default: begin
                rdata_d = 32'h0000_0000;
                hit_d = 1'b0;
            end
        endcase
    end
    assign pready = psel & penable;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : rdata_d;
            pslverr <= !hit_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers.
    // Writing one keeps an enable that is already set; only a fresh set needs the read first.
    wire logic me_set = wr_dst_ctrl && pwdata[`BIT_ENABLE] && (armed_me_q || me);
    wire logic ce_set = wr_src_ctrl && pwdata[`BIT_ENABLE] && (armed_ce_q || ce);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_ctrl_q <= `CTRL_RESET;
            dst_ctrl_q <= `CTRL_RESET;
        end else if (standby) begin
            src_ctrl_q <= `CTRL_RESET;
            dst_ctrl_q <= `CTRL_RESET;
        end else begin
            if (wr_src_ctrl)
                src_ctrl_q <= {ce_set, pwdata[6:0]};
            if (done)
                src_ctrl_q[`BIT_ENABLE] <= 1'b0;
            if (wr_dst_ctrl)
                dst_ctrl_q <= {me_set, pwdata[6:0]};
            if (nmi_rise)
                dst_ctrl_q[`BIT_ENABLE] <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            armed_me_q <= 1'b0;
            armed_ce_q <= 1'b0;
        end else begin
            if (rd_dst_ctrl)
                armed_me_q <= !me;
            else if (wr_dst_ctrl || standby)
                armed_me_q <= 1'b0;
            if (rd_src_ctrl)
                armed_ce_q <= !ce;
            else if (wr_src_ctrl || standby)
                armed_ce_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Addresses and counters; they move only on a real step, so a suspend holds them.
    always_ff @(posedge clk_sys) begin
        if (wr_src_addr)
            src_addr_q <= pwdata[23:0];
        else if (step)
            src_addr_q <= restore_src ? blk_start_q : src_next;
        if (wr_dst_addr)
            dst_addr_q <= pwdata[23:0];
        else if (step)
            dst_addr_q <= restore_dst ? blk_start_q : dst_next;
        if (state_q == ST_IDLE && state_d == ST_REQ && blk)
            blk_start_q <= area_src ? src_addr_q : dst_addr_q;
        if (wr_count)
            count_q <= pwdata[15:0];
        else if (step && blk)
            count_q[15:8] <= blk_last ? count_q[7:0] : count_q[15:8] - 8'h01;
        else if (step)
            count_q <= count_q - 16'h0001;
        if (wr_blocks)
            blocks_q <= pwdata[15:0];
        else if (step && blk_end)
            blocks_q <= blocks_q - 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer, pending request, interrupts and transfer output.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            pend_q <= 1'b0;
            nmi_prev_q <= 1'b0;
            ereq_prev_q <= 1'b1;
            stat_q <= 2'b00;
            mask_q <= 2'b00;
            xfer <= '0;
            transfer_end_interrupt <= 1'b0;
        end else begin
            state_q <= state_d;
            nmi_prev_q <= nmi_s;
            ereq_prev_q <= ereq_s;
            pend_q <= event_set | (pend_q & ~(state_q == ST_IDLE && state_d == ST_REQ) & ~standby);
            stat_q[`IRQ_END] <= (done & src_ctrl_q[`BIT_IRQ_EN]) |
                                (stat_q[`IRQ_END] & ~(wr_stat & pwdata[`IRQ_END]));
            stat_q[`IRQ_NMI] <= nmi_rise | (stat_q[`IRQ_NMI] & ~(wr_stat & pwdata[`IRQ_NMI]));
            if (wr_mask)
                mask_q <= pwdata[1:0];
            xfer.valid <= step;
            xfer.word <= word;
            xfer.src <= src_addr_q;
            xfer.dst <= dst_addr_q;
            transfer_end_interrupt <= done & src_ctrl_q[`BIT_IRQ_EN];
        end
    end

    assign irq = |(stat_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire logic wr_any = wr_en;
    // Address and count registers have no reset, so the hold check waits until software has loaded them.
    logic src_seen_q;
    logic cnt_seen_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_seen_q <= 1'b0;
            cnt_seen_q <= 1'b0;
        end else begin
            if (wr_src_addr)
                src_seen_q <= 1'b1;
            if (wr_count)
                cnt_seen_q <= 1'b1;
        end
    end

    chk_xfer_needs_enable: assert property (xfer.valid |-> $past(me && ce))
        else $error("Transfer issued without both enables");
    chk_nmi_clears_me: assert property (nmi_rise |=> !me)
        else $error("Master enable survived an NMI");
    chk_standby_zero: assert property (standby |=> dst_ctrl_q == 8'h00 && !blk)
        else $error("Standby did not clear control registers");
    chk_me_needs_read: assert property ($rose(me) |-> $past(armed_me_q))
        else $error("Master enable set without prior read");
    chk_reserved_kept: assert property (wr_dst_ctrl && !standby |=> dst_ctrl_q[`BIT_RESV] == $past(pwdata[6]))
        else $error("Reserved bit did not store written value");
    chk_dst_fixed: assert property (step && !dst_ctrl_q[`BIT_STEP] && !blk && !wr_any
                                    |=> $stable(dst_addr_q))
        else $error("Destination address moved while fixed");
    chk_dst_word_step: assert property (step && dst_ctrl_q[5:4] == 2'b01 && word && !blk && !wr_any
                                        |=> dst_addr_q == $past(dst_addr_q) + 24'h00_0002)
        else $error("Word step is not two");
    chk_done_clears_ce: assert property (done && !standby |=> !ce ##1 state_q != ST_XFER)
        else $error("Channel enable not cleared at completion");
    chk_block_reload: assert property (step && blk && blk_last && !wr_any
                                       |=> count_q[15:8] == $past(count_q[7:0]))
        else $error("Block size counter not reloaded");
    chk_steal_release: assert property (step && auto_steal |=> state_q == ST_REL ##1 !bus_request)
        else $error("Cycle-steal kept the bus");
    chk_burst_holds: assert property (step && auto_burst && !done && !bus_preempt |=> bus_request)
        else $error("Burst released the bus early");
    chk_suspend_hold: assert property (!run && !wr_any && src_seen_q && cnt_seen_q
                                       |=> $stable(src_addr_q) && $stable(count_q))
        else $error("Counts moved while suspended");
    chk_priority_defer: assert property (state_q == ST_IDLE && higher_channel_active |=> state_q == ST_IDLE)
        else $error("Channel started ahead of higher priority");

    cov_burst_done: cover property (step && auto_burst ##1 !ce);
    cov_block_end: cover property (step && blk_end);
    cov_nmi_resume: cover property (nmi_rise ##[1:200] $rose(me));
endmodule

//--- dv/bus_arbiter_model.sv
`timescale 1ns/1ps
module bus_arbiter_model #(
    parameter int GRANT_DELAY = 2
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset_n,
    // Request and grant.
    input wire logic bus_request,
    output logic bus_grant
);
    int wait_q;
    // A slow grant makes the channel hold its request; the grant goes as soon as the request does.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wait_q <= 0;
            bus_grant <= 1'b0;
        end else if (!bus_request) begin
            wait_q <= 0;
            bus_grant <= 1'b0;
        end else if (wait_q < GRANT_DELAY) begin
            wait_q <= wait_q + 1;
        end else begin
            bus_grant <= 1'b1;
        end
    end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
`include "dma_chan_defs.svh"
module tb_top;
    import dma_chan_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n, psel, penable, pwrite, pready, pslverr, nmi_pin, standby, ext_pin;
    logic bus_grant, bus_request, end_irq, irq, higher_active, preempt;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] timer_match;
    xfer_t xfer;
    logic [23:0] dst_q[$];
    int error_cnt = 0;
    int check_count = 0;
    int end_cnt = 0;
    int cyc = 0;

    always #50 clk_sys = ~clk_sys;

    dma_full_address_channel #(.TIMER_CH(4)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nmi_pin(nmi_pin), .standby(standby), .timer_match(timer_match),
        .external_request_pin(ext_pin), .higher_channel_active(higher_active), .bus_grant(bus_grant),
        .bus_preempt(preempt), .bus_request(bus_request), .xfer(xfer), .transfer_end_interrupt(end_irq), .irq(irq));

    bus_arbiter_model #(.GRANT_DELAY(2)) arb (.clk_sys(clk_sys), .reset_n(reset_n), .bus_request(bus_request),
        .bus_grant(bus_grant));

    always @(posedge clk_sys) begin
        if (xfer.valid === 1'b1) dst_q.push_back(xfer.dst);
        if (end_irq === 1'b1) end_cnt++;
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One transfer: setup, access until pready, then an idle cycle so calls never collide.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rd);
        chk(what, rd, exp);
    endtask

    task automatic wait_xfers(input int n);
        for (int i = 0; i < 300 && dst_q.size() < n; i++) @(posedge clk_sys);
    endtask

    // Enables go through the required read-seeing-zero then write-one sequence.
    task automatic arm(input logic [7:0] s, input logic [7:0] d, input logic [23:0] base, input logic [15:0] n);
        dst_q.delete();
        wr(`OFF_DST_CTRL, 32'h0000_0000);
        wr(`OFF_DST_ADDR, {8'h00, base});
        wr(`OFF_SRC_ADDR, 32'h0000_1000);
        wr(`OFF_COUNT, {16'h0000, n});
        wr(`OFF_SRC_CTRL, {24'h0, s});
        apb(1'b0, `OFF_SRC_CTRL, 32'h0000_0000, rd);
        wr(`OFF_SRC_CTRL, {24'h0, s | 8'h80});
        wr(`OFF_DST_CTRL, {24'h0, d});
        apb(1'b0, `OFF_DST_CTRL, 32'h0000_0000, rd);
        wr(`OFF_DST_CTRL, {24'h0, d | 8'h80});
    endtask

    task automatic expect_dst(input logic [23:0] base, input int step, input int n);
        logic [23:0] e;
        chk("transfer count", dst_q.size(), n);
        for (int i = 0; i < n && i < dst_q.size(); i++) begin
            e = base + 24'(i * step);
            chk("dest address", {8'h00, dst_q[i]}, {8'h00, e});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        {psel, penable, pwrite, nmi_pin, standby, higher_active, preempt} = '0;
        ext_pin = 1'b1;
        paddr = '0;
        pwdata = '0;
        timer_match = '0;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rdchk("source control", `OFF_SRC_CTRL, 32'h0000_0000);
        rdchk("dest control", `OFF_DST_CTRL, 32'h0000_0000);
        // The read above armed the master enable; a plain write disarms it again.
        wr(`OFF_DST_CTRL, 32'h0000_0000);
        wr(`OFF_DST_CTRL, 32'h0000_0080);
        rdchk("unarmed master enable", `OFF_DST_CTRL, 32'h0000_0000);
        wr(`OFF_DST_CTRL, 32'h0000_0040);
        rdchk("reserved bit", `OFF_DST_CTRL, 32'h0000_0040);
        standby <= 1'b1;
        repeat (2) @(posedge clk_sys);
        standby <= 1'b0;
        rdchk("dest control after standby", `OFF_DST_CTRL, 32'h0000_0000);
        apb(1'b0, 8'h24, 32'h0000_0000, rd);
        chk("unmapped error", pslverr, 1'b1);
        $display("test registers done");

        // Burst increment byte, word decrement, then cycle-steal with step off.
        arm(8'h08, 8'h10, 24'h00_0100, 16'h0002);
        wait_xfers(2);
        expect_dst(24'h00_0100, 1, 2);
        rdchk("channel enable cleared", `OFF_SRC_CTRL, 32'h0000_0008);
        chk("end pulse", end_cnt, 1);
        rdchk("end status", `OFF_IRQ_STAT, 32'h0000_0001);
        chk("irq masked", irq, 1'b0);
        wr(`OFF_IRQ_MASK, 32'h0000_0001);
        chk("irq unmasked", irq, 1'b1);
        wr(`OFF_IRQ_STAT, 32'h0000_0001);
        chk("irq cleared", irq, 1'b0);
        arm(8'h48, 8'h30, 24'h00_0200, 16'h0002);
        wait_xfers(2);
        expect_dst(24'h00_0200, -2, 2);
        arm(8'h08, 8'h22, 24'h00_0280, 16'h0003);
        wait_xfers(3);
        expect_dst(24'h00_0280, 0, 3);
        chk("end pulses", end_cnt, 3);
        $display("test normal transfers done");

        // Block mode on timer 1: timer 0 must not start it.
        arm(8'h09, 8'h11, 24'h00_0300, 16'h0202);
        wr(`OFF_BLOCKS, 32'h0000_0001);
        timer_match <= 4'b0001;
        @(posedge clk_sys);
        timer_match <= 4'b0000;
        repeat (20) @(posedge clk_sys);
        chk("wrong timer ignored", dst_q.size(), 0);
        timer_match <= 4'b0010;
        @(posedge clk_sys);
        timer_match <= 4'b0000;
        wait_xfers(2);
        expect_dst(24'h00_0300, 1, 2);
        repeat (10) @(posedge clk_sys);
        rdchk("block done", `OFF_SRC_CTRL, 32'h0000_0009);
        $display("test block mode done");

        // Pin-fall channel suspended by the non-maskable interrupt, then resumed.
        wr(`OFF_IRQ_STAT, 32'h0000_0003);
        arm(8'h00, 8'h06, 24'h00_0400, 16'h0001);
        nmi_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        nmi_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rdchk("master enable after nmi", `OFF_DST_CTRL, 32'h0000_0006);
        rdchk("nmi status", `OFF_IRQ_STAT, 32'h0000_0002);
        ext_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        ext_pin <= 1'b1;
        repeat (20) @(posedge clk_sys);
        chk("suspended", dst_q.size(), 0);
        wr(`OFF_DST_CTRL, 32'h0000_0086);
        ext_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        ext_pin <= 1'b1;
        wait_xfers(1);
        expect_dst(24'h00_0400, 0, 1);
        $display("test nmi done");

        // A higher channel holds off a low-level request; a preempting master splits a burst.
        higher_active <= 1'b1;
        arm(8'h40, 8'h17, 24'h00_0500, 16'h0002);
        ext_pin <= 1'b0;
        repeat (20) @(posedge clk_sys);
        chk("held by priority", dst_q.size(), 0);
        higher_active <= 1'b0;
        wait_xfers(2);
        ext_pin <= 1'b1;
        expect_dst(24'h00_0500, 2, 2);
        preempt <= 1'b1;
        arm(8'h00, 8'h10, 24'h00_0600, 16'h0003);
        wait_xfers(3);
        preempt <= 1'b0;
        expect_dst(24'h00_0600, 1, 3);
        $display("test priority and preempt done");
        report_and_stop();
    end
endmodule
